// File: hw/cx_pkg.sv
`default_nettype none
package cx_pkg;

   localparam int          NUM_CP       = 8;
   localparam logic [3:0]  CP_FP_LO     = 4'hA;
   localparam logic [3:0]  CP_FP_HI     = 4'hB;
   localparam int          OPSEL_W      = 4;
   localparam int          IMM_W        = 13;
   localparam int          VEC_W        = 128;
   localparam int          CNT_W        = 16;

   localparam int          WB_ADR_W     = 4;
   localparam logic [3:0]  OFS_CTRL     = 4'h0;
   localparam logic [3:0]  OFS_STATUS   = 4'h4;
   localparam logic [3:0]  OFS_DONECNT  = 4'h8;
   localparam logic [3:0]  OFS_UNDEFCNT = 4'hC;
   localparam int          CTRL_EN_BIT  = 0;
   localparam int          CTRL_CLR_BIT = 1;
   localparam logic        CTRL_EN_RST  = 1'b1;
   localparam int          STAT_BUSY    = 0;
   localparam int          STAT_FPU     = 1;
   localparam int          STAT_ERR     = 2;
   localparam int          STAT_ROUTE   = 8;

   typedef enum logic [3:0] {
      CLS_INT1  = 4'h0,
      CLS_INT2  = 4'h1,
      CLS_INT3  = 4'h2,
      CLS_INT1P = 4'h3,
      CLS_INT2P = 4'h4,
      CLS_INT3P = 4'h5,
      CLS_VEC1  = 4'h6,
      CLS_VEC2  = 4'h7,
      CLS_VEC3  = 4'h8
   } cls_e;

   typedef enum logic [1:0] {
      VW_S = 2'b00,
      VW_D = 2'b01,
      VW_Q = 2'b10
   } vwid_e;

   typedef struct packed {
      logic       vecFile;
      logic [4:0] idx;
      logic       pair;
      logic       flags;
   } dest_s;

   typedef struct packed {
      logic [3:0]         cls;
      vwid_e              vwid;
      logic               acc;
      logic [3:0]         cpNum;
      logic [OPSEL_W-1:0] opSel;
      logic [IMM_W-1:0]   imm;
      logic [4:0]         dstIdx;
      logic               toFlags;
      logic [31:0]        rdEven;
      logic [31:0]        rdOdd;
      logic [3:0]         flagsIn;
      logic [VEC_W-1:0]   dstOld;
      logic [VEC_W-1:0]   srcA;
      logic [VEC_W-1:0]   srcB;
   } core_req_s;

   typedef struct packed {
      logic [3:0]         cls;
      vwid_e              vwid;
      logic               acc;
      logic [3:0]         cpNum;
      logic [OPSEL_W-1:0] opSel;
      logic [IMM_W-1:0]   imm;
      dest_s              dest;
      logic [VEC_W-1:0]   accVal;
      logic [VEC_W-1:0]   opA;
      logic [VEC_W-1:0]   opB;
   } dp_req_s;

   typedef struct packed {
      dest_s            dest;
      logic [VEC_W-1:0] result;
      logic [3:0]       flags;
   } dp_rsp_s;

   typedef struct packed {
      dest_s            dest;
      logic             we;
      logic             flagWe;
      logic [VEC_W-1:0] data;
      logic [3:0]       flags;
   } wb_s;

   function automatic logic [VEC_W-1:0] widthMask(input vwid_e w);
      logic [VEC_W-1:0] m;
      m = {VEC_W{1'b1}};
      unique case (w)
         VW_S:    m = {{(VEC_W-32){1'b0}}, {32{1'b1}}};
         VW_D:    m = {{(VEC_W-64){1'b0}}, {64{1'b1}}};
         default: m = {VEC_W{1'b1}};
      endcase
      return m;
   endfunction : widthMask

endpackage : cx_pkg
`default_nettype wire

// File: hw/operand_former.sv
`default_nettype none
module operand_former
   import cx_pkg::*;
#(
   parameter bit FPU_PRESENT = 1'b1
) (
   input  wire core_req_s req,
   output dp_req_s        dpReq,
   output logic           illegal
);

   logic             isVec;
   logic             isPair;
   logic [1:0]       nSrc;
   logic [VEC_W-1:0] mask;

   always_comb begin
      isVec  = (req.cls >= CLS_VEC1) && (req.cls <= CLS_VEC3);
      isPair = (req.cls >= CLS_INT1P) && (req.cls <= CLS_INT3P);
      unique case (req.cls)
         CLS_INT2, CLS_INT2P, CLS_VEC2: nSrc = 2'd2;
         CLS_INT3, CLS_INT3P, CLS_VEC3: nSrc = 2'd3;
         default:                       nSrc = 2'd1;
      endcase
      // Integer operands live in the low word of the wide lane. [RQ8] [RQ10] [RQ11] [RQ12]
      mask = isVec ? widthMask(req.vwid) : {{(VEC_W-32){1'b0}}, {32{1'b1}}};

      dpReq.cls        = req.cls;
      dpReq.vwid       = isVec ? req.vwid : VW_S;
      dpReq.acc        = req.acc;
      dpReq.cpNum      = req.cpNum;
      dpReq.opSel      = req.opSel; // [RQ4]
      dpReq.imm        = req.imm;   // [RQ4]
      dpReq.dest.vecFile = isVec;   // [RQ1] [RQ2]
      dpReq.dest.idx   = req.dstIdx;
      dpReq.dest.pair  = isPair;    // [RQ9]
      dpReq.dest.flags = req.toFlags && !isVec && !isPair; // [RQ5]
      dpReq.opA        = (nSrc >= 2'd2) ? (req.srcA & mask) : '0;
      dpReq.opB        = (nSrc == 2'd3) ? (req.srcB & mask) : '0;

      // The old destination is a source only in accumulate form. [RQ3]
      dpReq.accVal = '0;
      if (req.acc) begin
         if (isVec) begin
            dpReq.accVal = req.dstOld & mask;
         end else if (isPair) begin
            dpReq.accVal = {{(VEC_W-64){1'b0}}, req.rdOdd, req.rdEven}; // [RQ7]
         end else if (req.toFlags) begin
            dpReq.accVal = {{(VEC_W-4){1'b0}}, req.flagsIn};
         end else begin
            dpReq.accVal = {{(VEC_W-32){1'b0}}, req.rdEven};
         end
      end

      illegal = 1'b0;
      if (req.cls > CLS_VEC3) illegal = 1'b1;
      if (req.cpNum >= 4'(NUM_CP)) illegal = 1'b1;                       // [RQ15]
      if (req.cpNum == CP_FP_LO || req.cpNum == CP_FP_HI) illegal = 1'b1; // [RQ15]
      if (isPair && (req.dstIdx[0] || req.toFlags)) illegal = 1'b1;       // [RQ7]
      if (isVec && req.toFlags) illegal = 1'b1;                           // [RQ5] [RQ6]
      if (isVec && req.vwid == 2'b11) illegal = 1'b1;
      if (isVec && !FPU_PRESENT) illegal = 1'b1;                          // [RQ14]
   end

endmodule : operand_former
`default_nettype wire

// File: hw/cx_wb_regs.sv
`default_nettype none
module cx_wb_regs
   import cx_pkg::*;
(
   input  wire logic                clk_sys,
   input  wire logic                srst,
   input  wire logic                wb_cyc_i,
   input  wire logic                wb_stb_i,
   input  wire logic                wb_we_i,
   input  wire logic [WB_ADR_W-1:0] wb_adr_i,
   input  wire logic [31:0]         wb_dat_i,
   input  wire logic [3:0]          wb_sel_i,
   output logic [31:0]              wb_dat_o,
   output logic                     wb_ack_o,
   output logic                     enable,
   output logic                     clearCnt,
   input  wire logic [31:0]         statusWord,
   input  wire logic [CNT_W-1:0]    doneCnt,
   input  wire logic [CNT_W-1:0]    undefCnt
);

   logic        ack_q, ack_d;
   logic        en_q, en_d;
   logic        clr_q, clr_d;
   logic [31:0] dat_q, dat_d;
   logic        hit;

   always_comb begin
      hit   = wb_cyc_i && wb_stb_i && !ack_q;
      ack_d = hit;
      en_d  = en_q;
      clr_d = 1'b0;
      dat_d = dat_q;
      if (hit && wb_we_i && wb_adr_i == OFS_CTRL && wb_sel_i[0]) begin
         en_d  = wb_dat_i[CTRL_EN_BIT];
         clr_d = wb_dat_i[CTRL_CLR_BIT];
      end
      if (hit && !wb_we_i) begin
         unique case (wb_adr_i)
            OFS_CTRL:     dat_d = {31'h0, en_q};
            OFS_STATUS:   dat_d = statusWord;
            OFS_DONECNT:  dat_d = {{(32-CNT_W){1'b0}}, doneCnt};
            OFS_UNDEFCNT: dat_d = {{(32-CNT_W){1'b0}}, undefCnt};
            default:      dat_d = 32'h0;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         ack_q <= 1'b0;
         en_q  <= CTRL_EN_RST;
         clr_q <= 1'b0;
         dat_q <= 32'h0;
      end else begin
         ack_q <= ack_d;
         en_q  <= en_d;
         clr_q <= clr_d;
         dat_q <= dat_d;
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = dat_q;
   assign enable   = en_q;
   assign clearCnt = clr_q;

endmodule : cx_wb_regs
`default_nettype wire

// File: hw/custom_insn_port.sv
`default_nettype none
// Functional notes
// (RQ1) Three integer classes read and write GPRs, optionally the condition flags.
// (RQ2) Three vector classes use only the floating-point/vector register file.
// (RQ3) Accumulate forms pass the old destination as a source; others only write.
// (RQ4) Operation selector and immediate both reach the datapath.
// (RQ5) Vector-file instructions never write the condition flags.
// (RQ6) No instruction mixes integer and vector register files.
// (RQ7) Pair operand is even register low, following odd register high.
// (RQ8) Single-result integer classes write one 32-bit GPR or the flags.
// (RQ9) Pair integer classes write a register pair; accumulate also reads it.
// (RQ10) Single-width vector classes write one 32-bit register.
// (RQ11) Double-width vector classes write one 64-bit register.
// (RQ12) Quad-width vector classes write one 128-bit register.
// (RQ13) Per coprocessor number a build option picks datapath or coprocessor.
// (RQ14) Without the floating-point unit, vector custom instructions are undefined.
// (RQ15) Only eight coprocessor numbers; floating-point numbers are never routed.
// (RQ16) Result returns with its destination; only that destination is written.
module custom_insn_port
   import cx_pkg::*;
#(
   parameter bit [NUM_CP-1:0] ROUTE_TO_DP = 8'hFF,
   parameter bit              FPU_PRESENT = 1'b1
) (
   input  wire logic                clk_sys,
   input  wire logic                srst,
   input  wire logic                wb_cyc_i,
   input  wire logic                wb_stb_i,
   input  wire logic                wb_we_i,
   input  wire logic [WB_ADR_W-1:0] wb_adr_i,
   input  wire logic [31:0]         wb_dat_i,
   input  wire logic [3:0]          wb_sel_i,
   output logic [31:0]              wb_dat_o,
   output logic                     wb_ack_o,
   input  wire logic                reqVld,
   output logic                     reqRdy,
   input  wire core_req_s           req,
   output logic                     cmpVld,
   output logic                     cmpUndef,
   output wb_s                      wbOut,
   output dp_req_s                  portReq,
   output logic                     dpReqVld,
   input  wire logic                dpReqRdy,
   input  wire logic                dpRspVld,
   output logic                     dpRspRdy,
   input  wire dp_rsp_s             dpRsp,
   output logic                     cpReqVld,
   input  wire logic                cpReqRdy,
   input  wire logic                cpRspVld,
   output logic                     cpRspRdy,
   input  wire dp_rsp_s             cpRsp
);

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_ISSUE = 2'b01,
      ST_WAIT  = 2'b10
   } state_e;

   state_e            state_q, state_d;
   dp_req_s           pend_q, pend_d;
   logic              route_q, route_d;
   logic              cmpVld_q, cmpVld_d;
   logic              cmpUndef_q, cmpUndef_d;
   wb_s               wb_q, wb_d;
   logic              err_q, err_d;
   logic [CNT_W-1:0]  done_q, done_d;
   logic [CNT_W-1:0]  undef_q, undef_d;

   dp_req_s           formed;
   logic              illegal;
   logic              enable;
   logic              clearCnt;
   logic              rspVld;
   dp_rsp_s           rsp;
   logic              portRdy;
   logic              destOk;
   logic [VEC_W-1:0]  resMask;
   logic [31:0]       statusWord;

   operand_former #(
      .FPU_PRESENT (FPU_PRESENT)
   ) u_former (
      .req     (req),
      .dpReq   (formed),
      .illegal (illegal)
   );

   always_comb begin
      statusWord = '0;
      statusWord[STAT_BUSY] = (state_q != ST_IDLE);
      statusWord[STAT_FPU]  = FPU_PRESENT;
      statusWord[STAT_ERR]  = err_q;
      statusWord[STAT_ROUTE +: NUM_CP] = ROUTE_TO_DP;
   end

   cx_wb_regs u_regs (
      .clk_sys    (clk_sys),
      .srst       (srst),
      .wb_cyc_i   (wb_cyc_i),
      .wb_stb_i   (wb_stb_i),
      .wb_we_i    (wb_we_i),
      .wb_adr_i   (wb_adr_i),
      .wb_dat_i   (wb_dat_i),
      .wb_sel_i   (wb_sel_i),
      .wb_dat_o   (wb_dat_o),
      .wb_ack_o   (wb_ack_o),
      .enable     (enable),
      .clearCnt   (clearCnt),
      .statusWord (statusWord),
      .doneCnt    (done_q),
      .undefCnt   (undef_q)
   );

   // Only one instruction is in flight, so the core stalls until it completes.
   assign reqRdy   = (state_q == ST_IDLE);
   assign portReq  = pend_q;
   assign dpReqVld = (state_q == ST_ISSUE) && route_q;  // [RQ13]
   assign cpReqVld = (state_q == ST_ISSUE) && !route_q; // [RQ13]
   assign dpRspRdy = (state_q == ST_WAIT) && route_q;
   assign cpRspRdy = (state_q == ST_WAIT) && !route_q;
   assign cmpVld   = cmpVld_q;
   assign cmpUndef = cmpUndef_q;
   assign wbOut    = wb_q;

   always_comb begin
      rspVld  = route_q ? dpRspVld : cpRspVld;
      rsp     = route_q ? dpRsp : cpRsp;
      portRdy = route_q ? dpReqRdy : cpReqRdy;
      destOk  = (rsp.dest == pend_q.dest); // [RQ16]
      resMask = pend_q.dest.vecFile ? widthMask(pend_q.vwid) :
                pend_q.dest.pair ? {{(VEC_W-64){1'b0}}, {64{1'b1}}} :
                {{(VEC_W-32){1'b0}}, {32{1'b1}}};
   end

   always_comb begin
      state_d    = state_q;
      pend_d     = pend_q;
      route_d    = route_q;
      cmpVld_d   = 1'b0;
      cmpUndef_d = 1'b0;
      wb_d       = wb_q;
      wb_d.we    = 1'b0;
      wb_d.flagWe = 1'b0;
      // Software clear is applied first, so an event in the same cycle still counts.
      err_d      = clearCnt ? 1'b0 : err_q;
      done_d     = clearCnt ? '0 : done_q;
      undef_d    = clearCnt ? '0 : undef_q;
      unique case (state_q)
         ST_IDLE: begin
            if (reqVld) begin
               if (illegal || !enable) begin
                  cmpVld_d   = 1'b1; // [RQ6] [RQ14] [RQ15]
                  cmpUndef_d = 1'b1;
                  undef_d    = undef_d + 1'b1;
               end else begin
                  pend_d  = formed;
                  route_d = ROUTE_TO_DP[formed.cpNum[2:0]]; // [RQ13]
                  state_d = ST_ISSUE;
               end
            end
         end
         ST_ISSUE: begin
            if (portRdy) begin
               state_d = ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (rspVld) begin
               cmpVld_d = 1'b1;
               state_d  = ST_IDLE;
               wb_d.dest = pend_q.dest;
               if (destOk) begin
                  // A mismatched destination is dropped so no wrong register is hit.
                  wb_d.we     = !pend_q.dest.flags;            // [RQ8] [RQ9]
                  wb_d.flagWe = pend_q.dest.flags && !pend_q.dest.vecFile; // [RQ5]
                  wb_d.data   = rsp.result & resMask;          // [RQ10] [RQ11] [RQ12]
                  wb_d.flags  = rsp.flags;
                  done_d      = done_d + 1'b1;
               end else begin
                  cmpUndef_d = 1'b1;
                  err_d      = 1'b1;
               end
            end
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         state_q    <= ST_IDLE;
         pend_q     <= '0;
         route_q    <= 1'b0;
         cmpVld_q   <= 1'b0;
         cmpUndef_q <= 1'b0;
         wb_q       <= '0;
         err_q      <= 1'b0;
         done_q     <= '0;
         undef_q    <= '0;
      end else begin
         state_q    <= state_d;
         pend_q     <= pend_d;
         route_q    <= route_d;
         cmpVld_q   <= cmpVld_d;
         cmpUndef_q <= cmpUndef_d;
         wb_q       <= wb_d;
         err_q      <= err_d;
         done_q     <= done_d;
         undef_q    <= undef_d;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);

   property p_vec_no_flags;
      (cmpVld && wbOut.dest.vecFile) |-> !wbOut.flagWe;
   endproperty
   a_vec_no_flags: assert property (p_vec_no_flags) else $error("vector op wrote flags"); // [RQ5]

   property p_pair_even;
      (portReq.dest.pair && (dpReqVld || cpReqVld)) |-> !portReq.dest.idx[0];
   endproperty
   a_pair_even: assert property (p_pair_even) else $error("pair issued on odd register"); // [RQ7]

   property p_route;
      (dpReqVld || cpReqVld) |-> (dpReqVld == ROUTE_TO_DP[portReq.cpNum[2:0]]);
   endproperty
   a_route: assert property (p_route) else $error("instruction sent to wrong unit"); // [RQ13]

   property p_cp_range;
      (dpReqVld || cpReqVld) |-> (portReq.cpNum < 4'(NUM_CP));
   endproperty
   a_cp_range: assert property (p_cp_range) else $error("reserved coprocessor routed"); // [RQ15]

   property p_no_fpu;
      (dpReqVld || cpReqVld) |-> (FPU_PRESENT || !portReq.dest.vecFile);
   endproperty
   a_no_fpu: assert property (p_no_fpu) else $error("vector op without fpu"); // [RQ14]

   property p_wb_dest;
      (state_q == ST_WAIT && rspVld && destOk) |=>
         (cmpVld && !cmpUndef && wbOut.dest == $past(pend_q.dest)
          && wbOut.data == ($past(rsp.result) & $past(resMask)));
   endproperty
   a_wb_dest: assert property (p_wb_dest) else $error("write-back target mismatch"); // [RQ16]

   property p_bad_dest;
      (state_q == ST_WAIT && rspVld && !destOk) |=> (cmpUndef && !wbOut.we && !wbOut.flagWe);
   endproperty
   a_bad_dest: assert property (p_bad_dest) else $error("wrong destination written"); // [RQ16]

   property p_acc_zero;
      ((dpReqVld || cpReqVld) && !portReq.acc) |-> (portReq.accVal == '0);
   endproperty
   a_acc_zero: assert property (p_acc_zero) else $error("non-accumulate passed old value"); // [RQ3]

   property p_illegal;
      (reqVld && reqRdy && illegal) |=> (cmpVld && cmpUndef) ##1 (state_q == ST_IDLE);
   endproperty
   a_illegal: assert property (p_illegal) else $error("illegal request not undefined"); // [RQ6]

   property p_issue_hold;
      (state_q == ST_ISSUE && !portRdy) |=> (state_q == ST_ISSUE) && $stable(portReq);
   endproperty
   a_issue_hold: assert property (p_issue_hold) else $error("request changed while stalled"); // [RQ4]

   property p_int_width;
      (wbOut.we && !wbOut.dest.vecFile && !wbOut.dest.pair) |-> (wbOut.data[VEC_W-1:32] == '0);
   endproperty
   a_int_width: assert property (p_int_width) else $error("integer result wider than word"); // [RQ8]

   property p_no_port_on_undef;
      (reqVld && reqRdy && (illegal || !enable)) |=> !(dpReqVld || cpReqVld);
   endproperty
   a_no_port_on_undef: assert property (p_no_port_on_undef) else $error("refused op reached unit"); // [RQ15]

   property p_pair_width;
      (wbOut.we && wbOut.dest.pair) |-> (wbOut.data[VEC_W-1:64] == '0);
   endproperty
   a_pair_width: assert property (p_pair_width) else $error("pair result wider than two words"); // [RQ9]

   property p_flag_excl;
      wbOut.flagWe |-> (!wbOut.we && !wbOut.dest.pair && !wbOut.dest.vecFile);
   endproperty
   a_flag_excl: assert property (p_flag_excl) else $error("flags written with a register"); // [RQ8]

endmodule : custom_insn_port
`default_nettype wire

// File: bench/dp_unit_model.sv
`default_nettype none
module dp_unit_model
   import cx_pkg::*;
(
   input  wire logic    clk_sys,
   input  wire dp_req_s portReq,
   input  wire logic    reqVld,
   output logic         reqRdy,
   output logic         rspVld,
   input  wire logic    rspRdy,
   output dp_rsp_s      rsp,
   input  wire logic    badDest,
   output int           nTaken
);
   timeunit 1ns;
   timeprecision 1ps;
   dp_req_s          held;
   logic [VEC_W-1:0] res;
   int               n;
   // Released response lines carry the inverse of the last answer so stale data never matches.
   initial begin
      reqRdy = 1'b0;
      rspVld = 1'b0;
      rsp    = '0;
      nTaken = 0;
      forever begin
         @(posedge clk_sys);
         if (reqVld) begin
            repeat ($urandom_range(2)) @(posedge clk_sys);
            reqRdy <= 1'b1;
            @(posedge clk_sys);
            held = portReq;
            reqRdy <= 1'b0;
            nTaken++;
            n = held.dest.vecFile ? (32 << held.vwid) : (held.dest.pair ? 64 : 32);
            res = held.opA ^ held.opB ^ held.accVal ^ VEC_W'({held.imm, held.opSel});
            res = res & ({VEC_W{1'b1}} >> (VEC_W - n));
            repeat ($urandom_range(2)) @(posedge clk_sys);
            rsp <= {held.dest ^ {5'h00, badDest, 2'b00}, res, res[3:0]};
            rspVld <= 1'b1;
            do @(posedge clk_sys); while (!rspRdy);
            rspVld <= 1'b0;
            rsp <= ~rsp;
         end
      end
   end
endmodule : dp_unit_model
`default_nettype wire

// File: bench/tb_custom_insn_datapath_port.sv
`default_nettype none
module tb_custom_insn_datapath_port
   import cx_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [NUM_CP-1:0] ROUTE = 8'h0F;
   logic        clk_sys, srst, wbCyc, wbStb, wbWe, wbAck, reqVld, reqRdy, cmpVld, cmpUndef;
   logic        dpReqVld, dpReqRdy, dpRspVld, dpRspRdy, cpReqVld, cpReqRdy, cpRspVld, cpRspRdy;
   logic        badDest;
   logic [3:0]  wbAdr, wbSel;
   logic [31:0] wbDat, wbDatO, q;
   core_req_s   req, r;
   wb_s         wbOut;
   dp_req_s     portReq;
   dp_rsp_s     dpRsp, cpRsp;
   int          dpN, cpN;
   int          fail_count = 0;
   int          n_compared = 0;
   int          cycles = 0;

   custom_insn_port #(.ROUTE_TO_DP(ROUTE), .FPU_PRESENT(1'b1)) u_dut (
      .clk_sys(clk_sys), .srst(srst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
      .wb_adr_i(wbAdr), .wb_dat_i(wbDat), .wb_sel_i(wbSel), .wb_dat_o(wbDatO),
      .wb_ack_o(wbAck), .reqVld(reqVld), .reqRdy(reqRdy), .req(req), .cmpVld(cmpVld),
      .cmpUndef(cmpUndef), .wbOut(wbOut), .portReq(portReq), .dpReqVld(dpReqVld),
      .dpReqRdy(dpReqRdy), .dpRspVld(dpRspVld), .dpRspRdy(dpRspRdy), .dpRsp(dpRsp),
      .cpReqVld(cpReqVld), .cpReqRdy(cpReqRdy), .cpRspVld(cpRspVld), .cpRspRdy(cpRspRdy),
      .cpRsp(cpRsp));

   dp_unit_model u_dp (.clk_sys(clk_sys), .portReq(portReq), .reqVld(dpReqVld),
      .reqRdy(dpReqRdy), .rspVld(dpRspVld), .rspRdy(dpRspRdy), .rsp(dpRsp),
      .badDest(badDest), .nTaken(dpN));
   dp_unit_model u_cp (.clk_sys(clk_sys), .portReq(portReq), .reqVld(cpReqVld),
      .reqRdy(cpReqRdy), .rspVld(cpRspVld), .rspRdy(cpRspRdy), .rsp(cpRsp),
      .badDest(badDest), .nTaken(cpN));

   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end

   task automatic report_and_stop();
      $display("Comparisons %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : report_and_stop

   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fail_count++;
         report_and_stop();
      end
   end

   task automatic chk(input logic [131:0] got, input logic [131:0] exp);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic tdone(input string s);
      $display("Test %s finished", s);
   endtask : tdone

   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
      int k;
      k = 0;
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      wbWe  <= w;
      wbAdr <= a;
      wbDat <= d;
      wbSel <= 4'hF;
      do begin
         @(posedge clk_sys);
         k++;
      end while (wbAck !== 1'b1 && k < 20);
      q = wbDatO;
      chk(wbAck, 1'b1);
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
      wbWe  <= 1'b0;
      @(posedge clk_sys);
   endtask : wb

   // Integer sources are single words even for pair classes; the result follows the destination.
   function automatic logic [131:0] expect_wb(input core_req_s x);
      logic [127:0] m, o, a, b, c;
      logic         v, p;
      int           ns;
      v  = x.cls >= 4'h6;
      p  = x.cls inside {[4'h3:4'h5]};
      ns = v ? int'(x.cls) - 5 : int'(x.cls) % 3 + 1;
      m  = {128{1'b1}} >> (128 - (v ? (32 << x.vwid) : (p ? 64 : 32)));
      o  = v ? m : 128'hFFFFFFFF;
      a  = ns >= 2 ? x.srcA & o : '0;
      b  = ns == 3 ? x.srcB & o : '0;
      c  = p ? 128'({x.rdOdd, x.rdEven}) : v ? x.dstOld & m : 128'(x.rdEven);
      if (x.toFlags) c = 128'(x.flagsIn);
      if (!x.acc) c = '0;
      a  = (a ^ b ^ c ^ 128'({x.imm, x.opSel})) & m;
      return {a, a[3:0]};
   endfunction : expect_wb

   function automatic core_req_s rnd_req(input int c);
      logic [511:0] v;
      core_req_s    x;
      v = '0;
      repeat (16) v = {v[479:0], $urandom()};
      x = v[$bits(core_req_s)-1:0];
      x.cls = 4'(c);
      x.vwid = vwid_e'($urandom_range(2));
      x.cpNum = 4'($urandom_range(7));
      if (c >= 3 && c <= 5) x.dstIdx[0] = 1'b0;
      if (c >= 3) x.toFlags = 1'b0;
      return x;
   endfunction : rnd_req

   task automatic do_insn(input core_req_s x, input logic xu, input logic xp);
      logic [131:0] e;
      logic         rt;
      int           d0, c0, k;
      e  = expect_wb(x);
      rt = xp & ROUTE[x.cpNum[2:0]];
      d0 = dpN;
      c0 = cpN;
      k  = 0;
      req <= x;
      reqVld <= 1'b1;
      do begin
         @(posedge clk_sys);
         k++;
      end while (reqRdy !== 1'b1 && k < 50);
      reqVld <= 1'b0;
      do begin
         @(posedge clk_sys);
         k++;
      end while (cmpVld !== 1'b1 && k < 100);
      chk({cmpVld, cmpUndef}, {1'b1, xu});
      chk({wbOut.we, wbOut.flagWe}, xu ? 2'b00 : (x.toFlags ? 2'b01 : 2'b10));
      chk({32'(dpN - d0), 32'(cpN - c0)}, {31'h0, rt, 31'h0, xp & ~rt});
      if (!xu) begin
         chk(wbOut.dest, {x.cls >= 4'h6, x.dstIdx, x.cls inside {[4'h3:4'h5]}, x.toFlags});
         if (x.toFlags) chk(wbOut.flags, e[3:0]);
         else chk(wbOut.data, e[131:4]);
      end
   endtask : do_insn

   initial begin
      {wbCyc, wbStb, wbWe, reqVld, badDest} = '0;
      wbAdr = '0;
      wbDat = '0;
      wbSel = '0;
      req   = '0;
      srst  = 1'b1;
      void'($urandom(32'hB19D));
      repeat (3) @(posedge clk_sys);
      srst <= 1'b0;
      wb(1'b0, OFS_CTRL, '0);
      chk(q[CTRL_EN_BIT], CTRL_EN_RST);
      wb(1'b0, OFS_STATUS, '0);
      chk({q[15:8], q[STAT_FPU]}, {ROUTE, 1'b1});
      wb(1'b0, 4'h2, '0);
      chk(q, 32'h0);
      tdone("registers");
      for (int c = 0; c < 9; c++) begin
         for (int a = 0; a < 2; a++) begin
            r = rnd_req(c);
            r.acc = a[0];
            r.vwid = vwid_e'((c + a) % 3);
            do_insn(r, 1'b0, 1'b1);
         end
      end
      repeat (60) do_insn(rnd_req($urandom_range(8)), 1'b0, 1'b1);
      wb(1'b0, OFS_DONECNT, '0);
      chk(q[CNT_W-1:0], 16'h004E);
      tdone("classes");
      wb(1'b1, OFS_CTRL, 32'h3);
      for (int i = 0; i < 8; i++) begin
         r = rnd_req(i % 3);
         case (i)
            0: r.cls = 4'h9;
            1: r.cpNum = 4'h8;
            2: r.cpNum = CP_FP_LO;
            3: r.cpNum = CP_FP_HI;
            4: {r.cls, r.dstIdx[0], r.toFlags} = {4'h4, 2'b10};
            5: {r.cls, r.toFlags} = {4'h7, 1'b1};
            6: begin
               {r.cls, r.toFlags} = {4'h8, 1'b0};
               r.vwid = vwid_e'(2'b11);
            end
            default: {r.cls, r.dstIdx[0], r.toFlags} = {4'h3, 2'b01};
         endcase
         do_insn(r, 1'b1, 1'b0);
      end
      wb(1'b0, OFS_UNDEFCNT, '0);
      chk(q[CNT_W-1:0], 16'h0008);
      tdone("refusals");
      badDest <= 1'b1;
      do_insn(rnd_req($urandom_range(8)), 1'b1, 1'b1);
      badDest <= 1'b0;
      wb(1'b0, OFS_STATUS, '0);
      chk(q[STAT_ERR], 1'b1);
      wb(1'b1, OFS_CTRL, 32'h0);
      do_insn(rnd_req(3), 1'b1, 1'b0);
      wb(1'b1, OFS_CTRL, 32'h3);
      wb(1'b0, OFS_STATUS, '0);
      chk(q[STAT_ERR], 1'b0);
      do_insn(rnd_req(8), 1'b0, 1'b1);
      tdone("mismatch and disable");
      report_and_stop();
   end
endmodule : tb_custom_insn_datapath_port
`default_nettype wire
